// ### panel_pkg.sv
package panel_pkg;

	// ============================================================
	// Timing
	localparam int CLK_HZ       = 100_000_000;
	localparam int CYC_PER_MS   = CLK_HZ / 1000;
	localparam int SLOW_HALF_MS = 500;
	localparam int FAST_HALF_MS = 100;
	localparam int SLOW_HALF_CYC = CYC_PER_MS * SLOW_HALF_MS;
	localparam int FAST_HALF_CYC = CYC_PER_MS * FAST_HALF_MS;

	// ============================================================
	// Key vector layout
	localparam int NKEYS   = 7;
	localparam int K_ESC   = 0;
	localparam int K_ENTER = 1;
	localparam int K_SHIFT = 2;
	localparam int K_JOG   = 3;
	localparam int K_RUN   = 4;
	localparam int K_DIR   = 5;
	localparam int K_STOP  = 6;

	// ============================================================
	// Menu ranges and edit digits
	localparam logic [4:0] MON_LAST   = 5'h12;
	localparam logic [4:0] MON_SETFRQ = 5'h03;
	localparam logic [4:0] MON_SETSPD = 5'h05;
	localparam logic [4:0] MON_PIDSET = 5'h0f;
	localparam logic [3:0] GRP_LAST   = 4'hf;
	localparam logic [5:0] CODE_LAST  = 6'h3f;
	localparam logic [1:0] DIGIT_LAST = 2'h3;
	localparam logic [3:0] BCD_MAX    = 4'h9;

	// ============================================================
	// Unit lamp codes
	localparam logic [2:0] U_NONE = 3'h0;
	localparam logic [2:0] U_HZ   = 3'h1;
	localparam logic [2:0] U_A    = 3'h2;
	localparam logic [2:0] U_RPM  = 3'h3;
	localparam logic [2:0] U_MS   = 3'h4;
	localparam logic [2:0] U_PCT  = 3'h5;
	localparam logic [2:0] U_V    = 3'h6;
	localparam logic [2:0] U_M    = 3'h7;

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		MENU_MON  = 2'b00,
		MENU_GRP  = 2'b01,
		MENU_CODE = 2'b11,
		MENU_VAL  = 2'b10
	} menu_t;

	typedef enum logic [1:0] {
		SRC_KEYPAD = 2'h0,
		SRC_TERM   = 2'h1,
		SRC_TERM_S = 2'h2,
		SRC_SERIAL = 2'h3
	} src_t;

	typedef enum logic [2:0] {
		DISP_MON   = 3'h0,
		DISP_WARN  = 3'h1,
		DISP_FAULT = 3'h2,
		DISP_GRP   = 3'h3,
		DISP_CODE  = 3'h4,
		DISP_VAL   = 3'h5
	} disp_t;

	typedef enum logic [1:0] {
		SP_FREQ = 2'h0,
		SP_SPD  = 2'h1,
		SP_PID  = 2'h2
	} sp_t;

	typedef struct packed {
		logic running;
		logic zero_freq;
		logic ramping;
		logic rev_running;
		logic fault;
		logic warning;
		src_t src;
		logic keypad_set_en;
	} drive_t;

	typedef struct packed {
		logic run;
		logic forward_lamp;
		logic reverse_lamp;
		logic fault;
		logic remote;
	} lamps_t;

endpackage : panel_pkg

// ### key_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser and press detector for the panel keys
module key_sync
(
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	// Raw keys, high while pressed
	input  wire logic [panel_pkg::NKEYS-1:0] keys_raw,
	// One-cycle press pulses
	output logic      [panel_pkg::NKEYS-1:0] press
);
	import panel_pkg::*;

	logic [NKEYS-1:0] s1_q;
	logic [NKEYS-1:0] s2_q;
	logic [NKEYS-1:0] old_q;

	// ============================================================
	// Synchroniser and edge detect
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			old_q <= '0;
		end
		else if (ce)
		begin
			s1_q  <= keys_raw;
			s2_q  <= s1_q;
			old_q <= s2_q;
		end
	end

	assign press = ce ? (s2_q & ~old_q) : '0;

endmodule : key_sync

// ### enc_step.sv
`timescale 1ns/1ps

// Quadrature knob decoder, one step per rising edge of phase A
module enc_step
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Knob phases
	input  wire logic enc_a,
	input  wire logic enc_b,
	// Step pulses
	output logic      step_cw,
	output logic      step_ccw
);
	import panel_pkg::*;

	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic       a_old_q;
	logic       a_rise;

	// ============================================================
	// Synchronise both phases
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s1_q    <= 2'h0;
			s2_q    <= 2'h0;
			a_old_q <= 1'b0;
		end
		else if (ce)
		begin
			s1_q    <= {enc_b, enc_a};
			s2_q    <= s1_q;
			a_old_q <= s2_q[0];
		end
	end

	// Phase B low at the A edge means clockwise
	assign a_rise   = ce & s2_q[0] & ~a_old_q;
	assign step_cw  = a_rise & ~s2_q[1];
	assign step_ccw = a_rise & s2_q[1];

endmodule : enc_step

// ### panel_ctrl.sv
`timescale 1ns/1ps

// Summary of operation
// - Escape key in monitoring enters programming at the group menu.
// - Enter key descends group, then code, then value menu.
// - Escape key climbs value to code to group to monitoring.
// - Escape while a fault or warning shows goes to the group menu.
// - Enter in the value menu writes the edited value to the parameter if it is editable and the drive is stopped.
// - Clockwise step raises group, code or value per current menu.
// - If the parameter is editable and the drive is stopped, the selected edit digit blinks and the knob changes that digit.
// - In monitoring with keypad setting on, knob adjusts the chosen setpoint.
// - Counterclockwise step acts as clockwise but lowers the number.
// - Shift key in the value menu selects another edit digit.
// - Shift key in monitoring steps to the next monitored quantity.
// - Jog key starts inching when the keypad is command source.
// - Run key issues a run command when the keypad is command source.
// - Direction key reverses the commanded rotation direction.
// - Three unit lamps encode the unit of the shown value.
// - Forward lamp off running in reverse, on stable, fast blink ramping.
// - Forward lamp blinks slowly when stopped with forward selected.
// - Reverse lamp on stable reverse, fast blink ramping in reverse.
// - Reverse lamp blinks slowly when stopped with reverse selected.
// - Run lamp on running, off stopped, blinking at zero frequency.
// - Source lamp off keypad, on terminal, blinking serial.
// - A reset refused by a lasting fault keeps fault code and lamp.
module panel_ctrl
#(
	parameter int SLOW_CYC = panel_pkg::SLOW_HALF_CYC,
	parameter int FAST_CYC = panel_pkg::FAST_HALF_CYC
)
(
	// Clock, reset, enable
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	// Keys and knob, raw pins
	input  wire logic [panel_pkg::NKEYS-1:0] keys_raw,
	input  wire logic                        enc_a,
	input  wire logic                        enc_b,
	// Drive state and parameter store
	input  wire panel_pkg::drive_t           drive,
	input  wire logic [15:0]                 param_value,
	input  wire logic                        param_editable,
	// Menu and display
	output panel_pkg::menu_t                 menu_q,
	output panel_pkg::disp_t                 disp_q,
	output logic [4:0]                       mon_sel_q,
	output logic [3:0]                       group_q,
	output logic [5:0]                       code_q,
	output logic [15:0]                      edit_q,
	output logic [3:0]                       digit_on_q,
	output logic [2:0]                       unit_q,
	output panel_pkg::lamps_t                lamps_q,
	// Parameter write
	output logic                             param_wr_q,
	output logic [9:0]                       param_addr_q,
	output logic [15:0]                      param_data_q,
	// Drive commands, one-cycle pulses except direction and setpoint select
	output logic                             run_cmd_q,
	output logic                             jog_cmd_q,
	output logic                             stop_cmd_q,
	output logic                             fault_clr_q,
	output logic                             dir_rev_q,
	output logic                             sp_up_q,
	output logic                             sp_dn_q,
	output panel_pkg::sp_t                   sp_sel_q
);
	import panel_pkg::*;

	// ============================================================
	// Helpers
	// Step one BCD digit up or down with wrap
	function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
		if (up)
			bcd_step = (d >= BCD_MAX) ? 4'h0 : d + 4'h1;
		else
			bcd_step = (d == 4'h0) ? BCD_MAX : d - 4'h1;
	endfunction : bcd_step

	// Unit lamp code of each monitored quantity
	function automatic logic [2:0] unit_of(input logic [4:0] m);
		case (m)
			5'h00, 5'h01, 5'h03: unit_of = U_HZ;
			5'h02:               unit_of = U_A;
			5'h04, 5'h05:        unit_of = U_RPM;
			5'h06, 5'h07:        unit_of = U_MS;
			5'h09:               unit_of = U_PCT;
			5'h0a, 5'h0b, 5'h0c,
			5'h0d:               unit_of = U_V;
			5'h12:               unit_of = U_M;
			default:             unit_of = U_NONE;
		endcase
	endfunction : unit_of

	// ============================================================
	// Input conditioning
	logic [NKEYS-1:0] press;
	logic             cw;
	logic             ccw;

	key_sync u_keys
	(
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.keys_raw (keys_raw),
		.press    (press)
	);

	enc_step u_enc
	(
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.enc_a    (enc_a),
		.enc_b    (enc_b),
		.step_cw  (cw),
		.step_ccw (ccw)
	);

	logic  esc_p;
	logic  ent_p;
	logic  shf_p;
	logic  turn;
	logic  keypad_src;
	logic  stop_ok;
	logic  fault_q;
	logic  edit_ok;
	logic  [1:0] digit_q;
	logic  [3:0] cur_dig;
	logic  [15:0] edit_d;

	assign esc_p      = press[K_ESC];
	assign ent_p      = press[K_ENTER];
	assign shf_p      = press[K_SHIFT];
	assign turn       = cw | ccw;
	assign keypad_src = (drive.src == SRC_KEYPAD);
	assign stop_ok    = keypad_src | (drive.src == SRC_TERM_S);
	assign edit_ok    = param_editable & ~drive.running;
	assign cur_dig    = edit_q[digit_q*4 +: 4];

	// ============================================================
	// Menu level state machine
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			menu_q <= MENU_MON;
		else if (ce)
		begin
			unique case (menu_q)
				MENU_MON:
					if (esc_p)
						menu_q <= MENU_GRP;
				MENU_GRP:
					if (esc_p)
						menu_q <= MENU_MON;
					else if (ent_p)
						menu_q <= MENU_CODE;
				MENU_CODE:
					if (esc_p)
						menu_q <= MENU_GRP;
					else if (ent_p)
						menu_q <= MENU_VAL;
				MENU_VAL:
					if (esc_p)
						menu_q <= MENU_CODE;
			endcase
		end
	end

	// ============================================================
	// Group and code selection by the knob
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			group_q <= 4'h0;
			code_q  <= 6'h00;
		end
		else if (ce)
		begin
			if (menu_q == MENU_GRP && cw)
				group_q <= (group_q == GRP_LAST) ? 4'h0 : group_q + 4'h1;
			else if (menu_q == MENU_GRP && ccw)
				group_q <= (group_q == 4'h0) ? GRP_LAST : group_q - 4'h1;
			if (menu_q == MENU_GRP && ent_p)
				code_q <= 6'h00;
			else if (menu_q == MENU_CODE && cw)
				code_q <= (code_q == CODE_LAST) ? 6'h00 : code_q + 6'h01;
			else if (menu_q == MENU_CODE && ccw)
				code_q <= (code_q == 6'h00) ? CODE_LAST : code_q - 6'h01;
		end
	end

	// ============================================================
	// Value edit buffer, loaded on entry to the value menu
	always_comb
	begin
		edit_d = edit_q;
		if (menu_q == MENU_CODE && ent_p)
			edit_d = param_value;
		else if (menu_q == MENU_VAL && turn && edit_ok)
			edit_d[digit_q*4 +: 4] = bcd_step(cur_dig, cw);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			edit_q <= 16'h0000;
		else if (ce)
			edit_q <= edit_d;
	end

	// Digit selection, lowest digit first on entry
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			digit_q <= 2'h0;
		else if (ce)
		begin
			if (menu_q == MENU_CODE && ent_p)
				digit_q <= 2'h0;
			else if (menu_q == MENU_VAL && shf_p)
				digit_q <= (digit_q == DIGIT_LAST) ? 2'h0 : digit_q + 2'h1;
		end
	end

	// ============================================================
	// Parameter store write
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			param_wr_q   <= 1'b0;
			param_addr_q <= 10'h000;
			param_data_q <= 16'h0000;
		end
		else if (ce)
		begin
			param_wr_q <= 1'b0;
			if (menu_q == MENU_VAL && ent_p && !esc_p && edit_ok) // Escape wins over enter
			begin
				param_wr_q   <= 1'b1;
				param_addr_q <= {group_q, code_q};
				param_data_q <= edit_q;
			end
		end
	end

	// ============================================================
	// Monitored quantity selection
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			mon_sel_q <= 5'h00;
		else if (ce && menu_q == MENU_MON && shf_p)
			mon_sel_q <= (mon_sel_q == MON_LAST) ? 5'h00 : mon_sel_q + 5'h01;
	end

	// Setpoint adjust from the knob while monitoring
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sp_up_q  <= 1'b0;
			sp_dn_q  <= 1'b0;
			sp_sel_q <= SP_FREQ;
		end
		else if (ce)
		begin
			sp_up_q <= menu_q == MENU_MON && drive.keypad_set_en && cw;
			sp_dn_q <= menu_q == MENU_MON && drive.keypad_set_en && ccw;
			if (mon_sel_q == MON_SETSPD)
				sp_sel_q <= SP_SPD;
			else if (mon_sel_q == MON_PIDSET)
				sp_sel_q <= SP_PID;
			else
				sp_sel_q <= SP_FREQ;
		end
	end

	// ============================================================
	// Drive commands
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			run_cmd_q   <= 1'b0;
			jog_cmd_q   <= 1'b0;
			stop_cmd_q  <= 1'b0;
			fault_clr_q <= 1'b0;
		end
		else if (ce)
		begin
			run_cmd_q   <= keypad_src & press[K_RUN];
			jog_cmd_q   <= keypad_src & press[K_JOG];
			stop_cmd_q  <= stop_ok & press[K_STOP] & ~fault_q;
			fault_clr_q <= press[K_STOP] & fault_q;
		end
	end

	// Commanded direction toggles on each direction key press
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			dir_rev_q <= 1'b0;
		else if (ce && press[K_DIR])
			dir_rev_q <= ~dir_rev_q;
	end

	// Fault latch, drops only when the drive reports it cleared
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			fault_q <= 1'b0;
		else if (ce)
			fault_q <= drive.fault;
	end

	// ============================================================
	// Blink timebases
	logic [31:0] slow_cnt_q;
	logic [31:0] fast_cnt_q;
	logic        slow_q;
	logic        fast_q;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			slow_cnt_q <= 32'h0;
			slow_q     <= 1'b0;
		end
		else if (ce)
		begin
			if (slow_cnt_q >= 32'(SLOW_CYC - 1))
			begin
				slow_cnt_q <= 32'h0;
				slow_q     <= ~slow_q;
			end
			else
				slow_cnt_q <= slow_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			fast_cnt_q <= 32'h0;
			fast_q     <= 1'b0;
		end
		else if (ce)
		begin
			if (fast_cnt_q >= 32'(FAST_CYC - 1))
			begin
				fast_cnt_q <= 32'h0;
				fast_q     <= ~fast_q;
			end
			else
				fast_cnt_q <= fast_cnt_q + 32'h1;
		end
	end

	// ============================================================
	// Display source, digit blanking and unit lamps
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			disp_q     <= DISP_MON;
			digit_on_q <= 4'hf;
			unit_q     <= U_NONE;
		end
		else if (ce)
		begin
			digit_on_q <= 4'hf;
			unit_q     <= U_NONE;
			unique case (menu_q)
				MENU_GRP:  disp_q <= DISP_GRP;
				MENU_CODE: disp_q <= DISP_CODE;
				MENU_VAL:
				begin
					disp_q <= DISP_VAL;
					if (edit_ok && !slow_q)
						digit_on_q[digit_q] <= 1'b0;
				end
				MENU_MON:
				begin
					if (fault_q)
						disp_q <= DISP_FAULT;
					else if (drive.warning)
					begin
						disp_q     <= DISP_WARN;
						digit_on_q <= {4{slow_q}};
					end
					else
					begin
						disp_q <= DISP_MON;
						unit_q <= unit_of(mon_sel_q);
					end
				end
			endcase
		end
	end

	// ============================================================
	// Status lamps
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			lamps_q <= '0;
		else if (ce)
		begin
			// Run lamp
			lamps_q.run <= drive.running & (drive.zero_freq ? slow_q : 1'b1);
			// Forward lamp
			if (!drive.running)
				lamps_q.forward_lamp <= ~dir_rev_q & slow_q;
			else if (drive.rev_running)
				lamps_q.forward_lamp <= 1'b0;
			else
				lamps_q.forward_lamp <= drive.ramping ? fast_q : 1'b1;
			// Reverse lamp
			if (!drive.running)
				lamps_q.reverse_lamp <= dir_rev_q & slow_q;
			else if (!drive.rev_running)
				lamps_q.reverse_lamp <= 1'b0;
			else
				lamps_q.reverse_lamp <= drive.ramping ? fast_q : 1'b1;
			// Fault lamp
			lamps_q.fault <= fault_q & slow_q;
			// Command source lamp
			unique case (drive.src)
				SRC_KEYPAD:          lamps_q.remote <= 1'b0;
				SRC_TERM, SRC_TERM_S: lamps_q.remote <= 1'b1;
				SRC_SERIAL:          lamps_q.remote <= slow_q;
			endcase
		end
	end

endmodule : panel_ctrl

// ### panel_ctrl_assertions.sv
`timescale 1ns/1ps

// ============================================================
// Port checks for the panel controller
module panel_ctrl_assertions
(
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              rst_n,
	// Drive state
	input wire panel_pkg::drive_t drive,
	// Menu and lamps
	input wire panel_pkg::menu_t  menu_q,
	input wire logic [3:0]        group_q,
	input wire logic [5:0]        code_q,
	input wire logic [15:0]       edit_q,
	input wire panel_pkg::lamps_t lamps_q,
	// Writes and commands
	input wire logic              param_wr_q,
	input wire logic [9:0]        param_addr_q,
	input wire logic [15:0]       param_data_q,
	input wire logic              run_cmd_q,
	input wire logic              jog_cmd_q,
	input wire logic              stop_cmd_q,
	input wire logic              sp_up_q,
	input wire logic              sp_dn_q
);
	import panel_pkg::*;

	// One clock domain throughout
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Menu climbs and descends one level at a time
	leave_mon_a: assert property (
		$past(menu_q) == MENU_MON && menu_q != MENU_MON |-> menu_q == MENU_GRP)
		else $error("monitoring left to a wrong level");
	from_group_a: assert property (
		$past(menu_q) == MENU_GRP && menu_q != MENU_GRP |-> menu_q inside {MENU_CODE, MENU_MON})
		else $error("group menu left to a wrong level");
	from_value_a: assert property (
		$past(menu_q) == MENU_VAL && menu_q != MENU_VAL |-> menu_q == MENU_CODE)
		else $error("value menu left to a wrong level");
	code_clear_a: assert property (
		$past(menu_q) == MENU_GRP && menu_q == MENU_CODE |-> code_q == 6'h00)
		else $error("code not cleared on entry");
	// Writes, commands and setpoint steps
	save_value_a: assert property (
		param_wr_q |-> menu_q == MENU_VAL && param_addr_q == {group_q, code_q}
			&& param_data_q == $past(edit_q))
		else $error("parameter write carries wrong place or value");
	src_refuse_a: assert property (
		(drive.src != SRC_KEYPAD) [*4] |-> !run_cmd_q && !jog_cmd_q)
		else $error("run or jog issued without keypad source");
	fault_stop_a: assert property (
		drive.fault [*4] |-> !stop_cmd_q)
		else $error("stop issued while a fault is present");
	setpoint_mon_a: assert property (
		sp_up_q || sp_dn_q |-> $past(menu_q) == MENU_MON && !(sp_up_q && sp_dn_q))
		else $error("setpoint stepped outside monitoring");
	// Lamps follow steady drive state
	run_lamp_a: assert property (
		(!drive.running) [*4] |-> !lamps_q.run)
		else $error("run lamp lit while stopped");
	remote_lamp_a: assert property (
		($stable(drive.src) && drive.src != SRC_SERIAL) [*4] |-> lamps_q.remote == (drive.src != SRC_KEYPAD))
		else $error("source lamp wrong");
	rev_lamp_a: assert property (
		(drive.running && drive.rev_running && !drive.ramping) [*4] |-> lamps_q.reverse_lamp && !lamps_q.forward_lamp)
		else $error("direction lamps wrong in steady reverse");

	// Main scenarios reached
	save_c: cover property (param_wr_q);
	stop_c: cover property (stop_cmd_q);
	sp_c: cover property (sp_up_q);
endmodule : panel_ctrl_assertions

bind panel_ctrl panel_ctrl_assertions panel_ctrl_assertions_inst
(
	.ref_clk, .rst_n, .drive, .menu_q, .group_q, .code_q, .edit_q, .lamps_q, .param_wr_q,
	.param_addr_q, .param_data_q, .run_cmd_q, .jog_cmd_q, .stop_cmd_q, .sp_up_q, .sp_dn_q
);

// ### operator_model.sv
`timescale 1ns/1ps

// ============================================================
// Operator at the keys and the knob
module operator_model
(
	// Clock
	input  wire logic                        ref_clk,
	// Keys and knob
	output logic      [panel_pkg::NKEYS-1:0] keys_raw,
	output logic                             enc_a,
	output logic                             enc_b
);
	import panel_pkg::*;

	// Nothing pressed at power up
	initial
	begin
		keys_raw = '0;
		enc_a = 1'b0;
		enc_b = 1'b0;
	end

	// Hold a key past the synchroniser, release, let the answer land
	task automatic press(input int k);
		@(posedge ref_clk) #1 keys_raw[k] = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 keys_raw[k] = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : press

	// One detent: phase B sets the sense before phase A rises
	task automatic turn(input logic cw);
		@(posedge ref_clk) #1 enc_b = !cw;
		@(posedge ref_clk) #1 enc_a = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 enc_a = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : turn
endmodule : operator_model

// ### keypad_menu_indicator_control_tb_top.sv
`timescale 1ns/1ps
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
`define KEY(k) operator_model_inst.press(k)
`define KNOB(c) operator_model_inst.turn(c)

// ============================================================
// Panel controller bench
module keypad_menu_indicator_control_tb_top;
	import panel_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	drive_t drv = '0;
	logic [6:0] keys;
	logic enc_a;
	logic enc_b;
	menu_t menu_q;
	disp_t disp_q;
	logic [4:0] mon_sel_q;
	logic [3:0] group_q;
	logic [3:0] digit_on_q;
	logic [5:0] code_q;
	logic [15:0] edit_q;
	logic [15:0] data;
	logic [15:0] wr_data;
	logic [9:0] addr;
	lamps_t lamps_q;
	logic wr;
	logic run;
	logic jog;
	logic stp;
	logic clr;
	logic dir;
	logic up;
	logic dn;
	logic ce = 1'b1;
	logic [2:0] unit;
	sp_t sp_sel;
	int run_n, jog_n, stop_n, clr_n, wr_n, up_n, dn_n, cyc, fails, num_checks;
	int tg[5];

	// Clock and hang guard
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fails++;
			summarize();
		end
	end

	// Count command pulses and capture writes
	always @(posedge ref_clk)
	begin
		run_n += (run === 1'b1);
		jog_n += (jog === 1'b1);
		stop_n += (stp === 1'b1);
		clr_n += (clr === 1'b1);
		up_n += (up === 1'b1);
		dn_n += (dn === 1'b1);
		wr_n += (wr === 1'b1);
		if (wr === 1'b1)
			wr_data = data;
	end

	operator_model operator_model_inst (.ref_clk(ref_clk), .keys_raw(keys), .enc_a(enc_a), .enc_b(enc_b));
	panel_ctrl #(.SLOW_CYC(8), .FAST_CYC(4)) panel_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.ce(ce), .keys_raw(keys), .enc_a(enc_a), .enc_b(enc_b), .drive(drv),
		.param_value(16'h1234), .param_editable(1'b1), .menu_q(menu_q), .disp_q(disp_q),
		.mon_sel_q(mon_sel_q), .group_q(group_q), .code_q(code_q), .edit_q(edit_q),
		.digit_on_q(digit_on_q), .unit_q(unit), .lamps_q(lamps_q), .param_wr_q(wr),
		.param_addr_q(addr), .param_data_q(data), .run_cmd_q(run), .jog_cmd_q(jog),
		.stop_cmd_q(stp), .fault_clr_q(clr), .dir_rev_q(dir), .sp_up_q(up), .sp_dn_q(dn),
		.sp_sel_q(sp_sel));

	// Lamp toggles over six slow half periods
	task automatic watch();
		lamps_t p;
		tg = '{default: 0};
		repeat (4) @(posedge ref_clk);
		#1 p = lamps_q;
		repeat (48)
		begin
			@(posedge ref_clk) #1;
			for (int i = 0; i < 5; i++)
				tg[i] += (lamps_q[i] !== p[i]);
			p = lamps_q;
		end
	endtask : watch

	// Blink class: 0 steady, 1 slow, 2 fast
	function automatic logic [1:0] bl(input int t);
		return (t == 0) ? 2'd0 : (t < 9) ? 2'd1 : 2'd2;
	endfunction : bl

	// Menu walk, edit, save and climb back
	task automatic t_menu();
		int z;
		`KEY(K_ESC);
		`CK("menu", MENU_GRP, menu_q)
		`KNOB(1);
		`KNOB(1);
		`CK("group", 4'h2, group_q)
		`KNOB(0);
		`CK("group", 4'h1, group_q)
		`KEY(K_ENTER);
		`CK("menu", MENU_CODE, menu_q)
		`KNOB(0);
		`CK("code", 6'h3f, code_q)
		`KNOB(1);
		`KEY(K_ENTER);
		`CK("edit", 16'h1234, edit_q)
		`KNOB(1);
		`CK("edit", 16'h1235, edit_q)
		`KEY(K_SHIFT);
		`KNOB(1);
		`CK("edit", 16'h1245, edit_q)
		z = 0;
		repeat (20)
		begin
			@(posedge ref_clk) #1;
			z += (digit_on_q === 4'hd);
		end
		`CK("blink", 1'b1, z > 0 && z < 20)
		`KEY(K_ENTER);
		`CK("writes", 1, wr_n)
		`CK("wdata", 16'h1245, wr_data)
		`CK("waddr", 10'h040, addr)
		`KEY(K_ESC);
		`CK("menu", MENU_CODE, menu_q)
		`KEY(K_ESC);
		`CK("menu", MENU_GRP, menu_q)
		`KEY(K_ESC);
		`CK("menu", MENU_MON, menu_q)
		$display("test menu done");
	endtask : t_menu

	// Monitored quantity and setpoint knob
	task automatic t_mon();
		drv.keypad_set_en = 1'b1;
		`KEY(K_SHIFT);
		`CK("mon", 5'h01, mon_sel_q)
		`CK("unit", U_HZ, unit)
		// A press while the clock enable is low must be lost
		ce = 1'b0;
		`KEY(K_SHIFT);
		ce = 1'b1;
		`CK("mon", 5'h01, mon_sel_q)
		`KNOB(1);
		`CK("up", 1, up_n)
		`KNOB(0);
		`CK("down", 1, dn_n)
		drv.keypad_set_en = 1'b0;
		`KNOB(1);
		`CK("up", 1, up_n)
		// Step to the speed setpoint, then to the PID setpoint
		repeat (4) `KEY(K_SHIFT);
		`CK("unit", U_RPM, unit)
		`CK("spsel", SP_SPD, sp_sel)
		repeat (10) `KEY(K_SHIFT);
		`CK("spsel", SP_PID, sp_sel)
		`CK("unit", U_NONE, unit)
		$display("test mon done");
	endtask : t_mon

	// Status lamps across drive states
	task automatic t_lamps();
		watch();
		`CK("fwd", 2'd1, bl(tg[3]))
		`CK("rev", 2'd0, bl(tg[2]) | lamps_q.reverse_lamp)
		`CK("fault_lamp", 2'd0, bl(tg[1]) | lamps_q.fault)
		drv.running = 1'b1;
		drv.ramping = 1'b1;
		watch();
		`CK("fwd", 2'd2, bl(tg[3]))
		`CK("run", 2'b11, {bl(tg[4]) == 2'd0, lamps_q.run})
		drv.ramping = 1'b0;
		watch();
		`CK("fwd", 2'b11, {bl(tg[3]) == 2'd0, lamps_q.forward_lamp})
		drv.rev_running = 1'b1;
		drv.ramping = 1'b1;
		watch();
		`CK("rev", 2'd2, bl(tg[2]))
		`CK("fwd", 2'd0, bl(tg[3]) | lamps_q.forward_lamp)
		drv.ramping = 1'b0;
		watch();
		`CK("rev", 2'b11, {bl(tg[2]) == 2'd0, lamps_q.reverse_lamp})
		drv.zero_freq = 1'b1;
		drv.src = SRC_SERIAL;
		watch();
		`CK("run", 2'd1, bl(tg[4]))
		`CK("remote", 2'd1, bl(tg[0]))
		drv = '0;
		$display("test lamps done");
	endtask : t_lamps

	// Commands by source, direction toggle
	task automatic t_cmds();
		`KEY(K_RUN);
		`CK("run", 1, run_n)
		`KEY(K_JOG);
		`CK("jog", 1, jog_n)
		`KEY(K_STOP);
		`CK("stop", 1, stop_n)
		`KEY(K_DIR);
		`CK("dir", 1'b1, dir)
		drv.src = SRC_TERM;
		`KEY(K_RUN);
		`KEY(K_STOP);
		`CK("run", 1, run_n)
		`CK("stop", 1, stop_n)
		drv.src = SRC_TERM_S;
		`KEY(K_RUN);
		`KEY(K_STOP);
		`CK("run", 1, run_n)
		`CK("stop", 2, stop_n)
		drv.src = SRC_KEYPAD;
		watch();
		`CK("rev", 2'd1, bl(tg[2]))
		`CK("fwd", 2'd0, bl(tg[3]) | lamps_q.forward_lamp)
		$display("test cmds done");
	endtask : t_cmds

	// Warning and fault display, escape and reset
	task automatic t_fault();
		drv.warning = 1'b1;
		@(posedge ref_clk) #1;
		`CK("disp", DISP_WARN, disp_q)
		`KEY(K_ESC);
		`CK("menu", MENU_GRP, menu_q)
		`KEY(K_ESC);
		drv.warning = 1'b0;
		drv.fault = 1'b1;
		watch();
		`CK("disp", DISP_FAULT, disp_q)
		`CK("fault_lamp", 2'd1, bl(tg[1]))
		`KEY(K_ESC);
		`CK("menu", MENU_GRP, menu_q)
		`KEY(K_ESC);
		`KEY(K_STOP);
		`CK("clear", 1, clr_n)
		`CK("stop", 2, stop_n)
		`CK("disp", DISP_FAULT, disp_q)
		drv.fault = 1'b0;
		watch();
		`CK("fault_lamp", 2'd0, bl(tg[1]) | lamps_q.fault)
		`CK("disp", DISP_MON, disp_q)
		$display("test fault done");
	endtask : t_fault

	// Counts and verdict
	task summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	// Reset, then every scenario in turn
	initial
	begin
		repeat (10) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		`CK("menu", MENU_MON, menu_q)
		`CK("digits", 4'hf, digit_on_q)
		t_menu();
		t_mon();
		t_lamps();
		t_cmds();
		t_fault();
		summarize();
	end
endmodule : keypad_menu_indicator_control_tb_top
